// ==== common/urx_pkg.sv ====
// Shared constants and types for the serial receive block
package urx_pkg;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] URX_OFF_STATUS = 8'h00;
	localparam logic [7:0] URX_OFF_CTRL = 8'h04;
	localparam logic [7:0] URX_OFF_FMT = 8'h08;
	localparam logic [7:0] URX_OFF_DATA = 8'h0c;
	localparam logic [7:0] URX_OFF_BAUD = 8'h10;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int URX_STAT_RXC = 7;
	localparam int URX_STAT_FE = 4;
	localparam int URX_STAT_DOR = 3;
	localparam int URX_STAT_PE = 2;
	localparam int URX_STAT_DS = 1;
	localparam int URX_CTRL_RXCIE = 7;
	localparam int URX_CTRL_RXEN = 4;
	localparam int URX_CTRL_GIE = 0;
	localparam int URX_FMT_PM1 = 5;
	localparam int URX_FMT_PM0 = 4;
	localparam int URX_FMT_SBS = 3;
	localparam int URX_FMT_CSZ_LO = 1;
	localparam int URX_BAUD_W = 12;

	// ****************************************
	// Reset values and timing counts
	// ****************************************
	localparam logic [1:0] URX_CSZ_RST = 2'h3;
	localparam logic [11:0] URX_BAUD_RST = 12'h000;
	localparam logic [4:0] URX_SMP_NORM = 5'h10;
	localparam logic [4:0] URX_SMP_DBL = 5'h08;
	localparam logic [4:0] URX_VOTE_NORM = 5'h08;
	localparam logic [4:0] URX_VOTE_DBL = 5'h04;
	localparam logic [2:0] URX_DBITS_BASE = 3'h4;
	localparam logic [1:0] URX_FIFO_DEPTH = 2'h2;

	typedef enum logic [2:0] {
		URX_IDLE = 3'b000,
		URX_START = 3'b001,
		URX_DATA = 3'b011,
		URX_PAR = 3'b010,
		URX_STOP = 3'b110
	} urx_state_t;

	typedef struct packed {
		logic fe;
		logic dor;
		logic pe;
		logic [7:0] data;
	} urx_entry_t;

endpackage : urx_pkg

// ==== rtl/urx_receiver.sv ====
// Serial receiver with start-bit recovery, two-entry FIFO and AHB-Lite registers
//
// The address map and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ns
module urx_receiver
	import urx_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Serial line and pin control
	input wire logic rx_in,
	output logic rx_pin_override,
	// Interrupt request
	output logic rx_irq
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic rx_irq;
		logic rx_override;
		logic ie;
		logic gie;
		logic rx_en;
		logic ds;
		logic pm1;
		logic pm0;
		logic sbs;
		logic [1:0] csz;
		logic [URX_BAUD_W-1:0] baud;
		logic [URX_BAUD_W-1:0] bcnt;
		logic tick;
		logic s1;
		logic s2;
		logic prev;
		urx_state_t st;
		logic [4:0] scnt;
		logic [1:0] vote;
		logic [2:0] bitn;
		logic [7:0] sh;
		logic pe_cur;
		logic hold_v;
		urx_entry_t hold;
		logic dor;
		urx_entry_t [1:0] fifo;
		logic rdp;
		logic wrp;
		logic [1:0] fcnt;
	} urx_regs_t;

	urx_regs_t r;
	urx_regs_t n;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic maj3(input logic a, input logic b, input logic c);
		maj3 = (a & b) | (a & c) | (b & c);
	endfunction : maj3

	function automatic logic [4:0] bit_len(input logic ds);
		bit_len = ds ? URX_SMP_DBL : URX_SMP_NORM;
	endfunction : bit_len

	function automatic logic [4:0] vote_first(input logic ds);
		vote_first = ds ? URX_VOTE_DBL : URX_VOTE_NORM;
	endfunction : vote_first

	function automatic logic [7:0] data_mask(input logic [1:0] csz);
		data_mask = 8'hff >> (2'h3 - csz);
	endfunction : data_mask

	logic take;
	logic pop;
	logic push;
	logic start_seen;
	logic overrun;
	logic frame_done;
	logic bitv;
	logic line;
	urx_entry_t head;
	logic [7:0] a;

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		n = r;
		pop = 1'b0;
		push = 1'b0;
		start_seen = 1'b0;
		overrun = 1'b0;
		frame_done = 1'b0;
		bitv = 1'b0;
		line = r.s2;
		head = r.fifo[r.rdp];
		a = haddr[7:0];

		n.s1 = rx_in;
		n.s2 = r.s1;

		// Sample tick: one per oversample point
		n.tick = (r.bcnt == '0);
		n.bcnt = (r.bcnt == '0) ? r.baud : r.bcnt - 1'b1;

		// Zero-wait slave: read data is registered in the address phase
		n.hreadyout = 1'b1;
		n.hresp = 1'b0;
		take = hsel && htrans[1] && hready;
		n.wr_pend = take && hwrite;
		if (take) begin
			n.wr_addr = a;
		end
		if (take && !hwrite) begin
			if (a == URX_OFF_STATUS) begin
				n.hrdata = '0;
				n.hrdata[URX_STAT_RXC] = (r.fcnt != '0);
				n.hrdata[URX_STAT_FE] = (r.fcnt != '0) && head.fe;
				n.hrdata[URX_STAT_DOR] = (r.fcnt != '0) && head.dor;
				n.hrdata[URX_STAT_PE] = (r.fcnt != '0) && head.pe && r.pm1;
				n.hrdata[URX_STAT_DS] = r.ds;
			end else if (a == URX_OFF_CTRL) begin
				n.hrdata = '0;
				n.hrdata[URX_CTRL_RXCIE] = r.ie;
				n.hrdata[URX_CTRL_RXEN] = r.rx_en;
				n.hrdata[URX_CTRL_GIE] = r.gie;
			end else if (a == URX_OFF_FMT) begin
				n.hrdata = '0;
				n.hrdata[URX_FMT_PM1] = r.pm1;
				n.hrdata[URX_FMT_PM0] = r.pm0;
				n.hrdata[URX_FMT_SBS] = r.sbs;
				n.hrdata[URX_FMT_CSZ_LO +: 2] = r.csz;
			end else if (a == URX_OFF_DATA) begin
				n.hrdata = {24'h000000, (r.fcnt != '0) ? head.data : 8'h00};
				pop = (r.fcnt != '0);
			end else if (a == URX_OFF_BAUD) begin
				n.hrdata = {20'h00000, r.baud};
			end else begin
				n.hrdata = '0;
			end
		end

		// Writes land in the data phase; error flags have no write path
		if (r.wr_pend) begin
			if (r.wr_addr == URX_OFF_STATUS) begin
				n.ds = hwdata[URX_STAT_DS];
			end else if (r.wr_addr == URX_OFF_CTRL) begin
				n.ie = hwdata[URX_CTRL_RXCIE];
				n.rx_en = hwdata[URX_CTRL_RXEN];
				n.gie = hwdata[URX_CTRL_GIE];
			end else if (r.wr_addr == URX_OFF_FMT) begin
				n.pm1 = hwdata[URX_FMT_PM1];
				n.pm0 = hwdata[URX_FMT_PM0];
				n.sbs = hwdata[URX_FMT_SBS];
				n.csz = hwdata[URX_FMT_CSZ_LO +: 2];
			end else if (r.wr_addr == URX_OFF_BAUD) begin
				n.baud = hwdata[URX_BAUD_W-1:0];
			end
		end

		// ****************************************
		// Clock and data recovery
		// ****************************************
		if (r.tick) begin
			n.prev = line;
			if (r.st == URX_IDLE) begin
				if (r.prev && !line) begin
					n.st = URX_START;
					// The edge tick itself was sample 1, so the next tick is sample 2
					n.scnt = 5'h02;
				end
			end else begin
				n.scnt = r.scnt + 5'h01;
				if (r.scnt == vote_first(r.ds) || r.scnt == vote_first(r.ds) + 5'h01) begin
					n.vote = {r.vote[0], line};
				end
				if (r.scnt == vote_first(r.ds) + 5'h02) begin
					bitv = maj3(r.vote[1], r.vote[0], line);
					case (r.st)
						URX_START: begin
							if (bitv) begin
								n.st = URX_IDLE;
							end else begin
								start_seen = 1'b1;
							end
						end
						URX_DATA: begin
							n.sh[r.bitn] = bitv;
						end
						URX_PAR: begin
							n.pe_cur = r.pm1 & (^(r.sh & data_mask(r.csz)) ^ bitv ^ r.pm0);
						end
						URX_STOP: begin
							// Later stop bits are left to the idle edge search
							frame_done = 1'b1;
							n.st = URX_IDLE;
						end
						default: begin
							n.st = URX_IDLE;
						end
					endcase
				end
				if (r.scnt == bit_len(r.ds) && r.st != URX_STOP) begin
					n.scnt = 5'h01;
					case (r.st)
						URX_START: begin
							n.st = URX_DATA;
							n.bitn = '0;
							n.sh = '0;
							n.pe_cur = 1'b0;
						end
						URX_DATA: begin
							if (r.bitn == {1'b0, r.csz} + URX_DBITS_BASE) begin
								n.st = r.pm1 ? URX_PAR : URX_STOP;
							end else begin
								n.bitn = r.bitn + 3'h1;
							end
						end
						URX_PAR: begin
							n.st = URX_STOP;
						end
						default: begin
							n.st = URX_IDLE;
						end
					endcase
				end
			end
		end

		// ****************************************
		// Hold register and FIFO
		// ****************************************
		push = r.hold_v && ((r.fcnt != URX_FIFO_DEPTH) || pop);
		if (push) begin
			n.fifo[r.wrp] = '{fe: r.hold.fe, dor: r.dor, pe: r.hold.pe, data: r.hold.data};
			n.wrp = ~r.wrp;
			n.hold_v = 1'b0;
			n.dor = 1'b0;
		end
		if (pop) begin
			n.rdp = ~r.rdp;
		end
		n.fcnt = r.fcnt + {1'b0, push} - {1'b0, pop};

		// The waiting frame is dropped when a new one starts behind a full FIFO
		overrun = start_seen && r.hold_v && !push;
		if (overrun) begin
			n.dor = 1'b1;
			n.hold_v = 1'b0;
		end
		if (frame_done) begin
			n.hold_v = 1'b1;
			n.hold.fe = !bitv;
			n.hold.dor = 1'b0;
			n.hold.pe = r.pe_cur;
			n.hold.data = r.sh & data_mask(r.csz);
		end

		// Disable cuts reception short and empties everything at once
		if (!r.rx_en) begin
			n.st = URX_IDLE;
			n.fcnt = '0;
			n.rdp = 1'b0;
			n.wrp = 1'b0;
			n.hold_v = 1'b0;
			n.dor = 1'b0;
		end

		// Error flags are deliberately kept out of the request
		n.rx_irq = (n.fcnt != '0) && n.ie && n.gie;
		n.rx_override = n.rx_en;
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
			r.hreadyout <= 1'b1;
			r.csz <= URX_CSZ_RST;
			r.baud <= URX_BAUD_RST;
			r.s1 <= 1'b1;
			r.s2 <= 1'b1;
			r.prev <= 1'b1;
			r.st <= URX_IDLE;
		end else begin
			r <= n;
		end
	end

	assign hreadyout = r.hreadyout;
	assign hresp = r.hresp;
	assign hrdata = r.hrdata;
	assign rx_pin_override = r.rx_override;
	assign rx_irq = r.rx_irq;

	// ****************************************
	// Checks
	// ****************************************
	a_flush_on_disable: assert property (@(posedge hclk) disable iff (!hresetn)
		!r.rx_en |=> (r.fcnt == '0) && !rx_irq)
		else $error("FIFO not flushed after disable");

	a_irq_follows_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		rx_irq == ((r.fcnt != '0) && r.ie && r.gie))
		else $error("Interrupt does not track complete flag");

	a_pop_moves_ptr: assert property (@(posedge hclk) disable iff (!hresetn)
		(take && !hwrite && a == URX_OFF_DATA && r.fcnt != '0 && r.rx_en) |=> (r.rdp != $past(r.rdp)))
		else $error("Data read did not advance the FIFO");

	a_no_irq_empty: assert property (@(posedge hclk) disable iff (!hresetn)
		(r.fcnt == '0) |-> !rx_irq)
		else $error("Interrupt raised with empty FIFO");

	a_overrun_sets: assert property (@(posedge hclk) disable iff (!hresetn)
		(overrun && r.rx_en) |=> r.dor ##1 (r.dor || $past(push)))
		else $error("Overrun not recorded");

	a_noise_reject: assert property (@(posedge hclk) disable iff (!hresetn)
		(r.st == URX_START && r.tick && r.rx_en && r.scnt == vote_first(r.ds) + 5'h02 &&
		maj3(r.vote[1], r.vote[0], r.s2)) |=> (r.st == URX_IDLE))
		else $error("Noisy start bit was accepted");

	a_sample_range: assert property (@(posedge hclk) disable iff (!hresetn)
		(r.st != URX_IDLE) |-> (r.scnt >= 5'h01 && r.scnt <= bit_len(r.ds)))
		else $error("Sample counter out of range");

	a_fifo_bound: assert property (@(posedge hclk) disable iff (!hresetn)
		r.fcnt <= URX_FIFO_DEPTH)
		else $error("FIFO count exceeds two");

	a_frame_stored: assert property (@(posedge hclk) disable iff (!hresetn)
		(frame_done && r.rx_en) |=> r.hold_v && (r.hold.fe == !$past(bitv)))
		else $error("Stop bit result not held");

endmodule : urx_receiver

// ==== tb/urx_line_model.sv ====
// Remote serial transmitter driving the receive line
`timescale 1ns/1ns
module urx_line_model (
	// Clock
	input wire logic hclk,
	// Serial line
	output logic rx_line
);
	initial rx_line = 1'b1;

	task automatic bit_out(input logic v, input int n);
		rx_line <= v;
		repeat (n) @(posedge hclk);
	endtask : bit_out

	// One frame, LSB first; par_inv flips the even parity bit
	task automatic send(input logic [7:0] d, input int nb, input int spb, input logic pen, input logic par_inv,
		input logic stop);
		logic [7:0] m;
		m = d & 8'((1 << nb) - 1);
		bit_out(1'b0, spb);
		for (int i = 0; i < nb; i++) begin
			bit_out(m[i], spb);
		end
		if (pen) begin
			bit_out(^m ^ par_inv, spb);
		end
		bit_out(stop, spb);
		// Short idle gap so the frame lands before the next bus access
		bit_out(1'b1, 4);
	endtask : send

	// Low spike too short to survive the start vote
	task automatic glitch(input int n);
		bit_out(1'b0, n);
		bit_out(1'b1, 40);
	endtask : glitch
endmodule : urx_line_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the serial receive block
`timescale 1ns/1ns
module tb_top;
	import urx_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, rx_line, rx_pin_override, rx_irq;
	logic [31:0] hrdata;
	logic [31:0] c_all, c_noie, dummy;
	int n_errors = 0;
	int n_checks = 0;
	int cnt;

	always #2 hclk = ~hclk;

	urx_receiver i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .rx_in(rx_line), .rx_pin_override(rx_pin_override), .rx_irq(rx_irq));
	urx_line_model i_line (.hclk(hclk), .rx_line(rx_line));

	// ****************************************
	// Bus and compare helpers
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s seen %h exp %h", $time, m, seen, exp);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, dummy);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		bus(1'b0, a, 32'h0, v);
		chk(v, e, "register read");
	endtask : rd

	function automatic logic [31:0] st(input logic c, input logic f, input logic o, input logic p);
		st = 32'h0;
		st[URX_STAT_RXC] = c;
		st[URX_STAT_FE] = f;
		st[URX_STAT_DOR] = o;
		st[URX_STAT_PE] = p;
	endfunction : st

	task automatic close_out;
		$display("errors %0d checks %0d", n_errors, n_checks);
		if (n_errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		chk(rx_pin_override, 0, "override at reset");
		chk(hresp, 0, "okay response");
		rd(URX_OFF_STATUS, 32'h0);
		rd(URX_OFF_FMT, 32'h6);
		rd(URX_OFF_BAUD, 32'h0);
		rd(8'h14, 32'h0);
	endtask : t_reset

	task automatic t_basic;
		wr(URX_OFF_CTRL, c_all);
		// Override is launched by the write edge; look one edge later
		@(posedge hclk);
		chk(rx_pin_override, 1, "override on");
		rd(URX_OFF_CTRL, c_all);
		i_line.send(8'ha5, 8, 16, 0, 0, 1);
		chk(rx_irq, 1, "irq raised");
		rd(URX_OFF_STATUS, st(1, 0, 0, 0));
		rd(URX_OFF_DATA, 32'ha5);
		rd(URX_OFF_STATUS, 32'h0);
		chk(rx_irq, 0, "irq dropped");
	endtask : t_basic

	task automatic t_errors;
		wr(URX_OFF_CTRL, c_noie);
		wr(URX_OFF_FMT, 32'h2e);
		i_line.send(8'h3c, 8, 16, 1, 1, 1);
		i_line.send(8'h81, 8, 16, 1, 0, 0);
		chk(rx_irq, 0, "no irq from errors");
		// Deliberately writes ones into the error positions
		wr(URX_OFF_STATUS, 32'h1c);
		rd(URX_OFF_STATUS, st(1, 0, 0, 1));
		rd(URX_OFF_DATA, 32'h3c);
		rd(URX_OFF_STATUS, st(1, 1, 0, 0));
		rd(URX_OFF_DATA, 32'h81);
	endtask : t_errors

	task automatic t_overrun;
		wr(URX_OFF_FMT, 32'h36);
		i_line.send(8'h11, 8, 16, 1, 1, 1);
		i_line.send(8'h22, 8, 16, 1, 1, 1);
		i_line.send(8'h33, 8, 16, 1, 1, 1);
		i_line.send(8'h44, 8, 16, 1, 1, 1);
		rd(URX_OFF_STATUS, st(1, 0, 0, 0));
		rd(URX_OFF_DATA, 32'h11);
		rd(URX_OFF_DATA, 32'h22);
		rd(URX_OFF_STATUS, st(1, 0, 1, 0));
		rd(URX_OFF_DATA, 32'h44);
		i_line.send(8'h55, 8, 16, 1, 1, 1);
		rd(URX_OFF_STATUS, st(1, 0, 0, 0));
		rd(URX_OFF_DATA, 32'h55);
	endtask : t_overrun

	task automatic t_flush;
		wr(URX_OFF_FMT, 32'h6);
		i_line.send(8'h5a, 8, 16, 0, 0, 1);
		i_line.send(8'h0f, 8, 16, 0, 0, 1);
		wr(URX_OFF_CTRL, 32'h0);
		// Flush lands one edge after the write
		@(posedge hclk);
		rd(URX_OFF_STATUS, 32'h0);
		chk(rx_pin_override, 0, "override off");
		wr(URX_OFF_CTRL, c_all);
		// Disable in mid-frame; the rest of the frame must be lost
		fork
			i_line.send(8'hff, 8, 16, 0, 0, 1);
			begin
				repeat (40) @(posedge hclk);
				wr(URX_OFF_CTRL, 32'h0);
				wr(URX_OFF_CTRL, c_all);
			end
		join
		rd(URX_OFF_STATUS, 32'h0);
		chk(rx_irq, 0, "irq after abandon");
	endtask : t_flush

	task automatic t_drain;
		logic [31:0] s, d;
		wr(URX_OFF_FMT, 32'h0);
		i_line.send(8'hff, 5, 16, 0, 0, 1);
		i_line.send(8'hff, 5, 16, 0, 0, 1);
		cnt = 0;
		bus(1'b0, URX_OFF_STATUS, 32'h0, s);
		while (s[URX_STAT_RXC] === 1'b1 && cnt < 4) begin
			bus(1'b0, URX_OFF_DATA, 32'h0, d);
			chk(d, 32'h1f, "short char");
			cnt++;
			bus(1'b0, URX_OFF_STATUS, 32'h0, s);
		end
		chk(32'(cnt), 32'h2, "drain count");
	endtask : t_drain

	task automatic t_noise_ds;
		i_line.glitch(4);
		rd(URX_OFF_STATUS, 32'h0);
		// Error positions written as zeros
		wr(URX_OFF_STATUS, 32'h2);
		wr(URX_OFF_FMT, 32'h6);
		i_line.send(8'hc3, 8, 8, 0, 0, 1);
		rd(URX_OFF_STATUS, st(1, 0, 0, 0) | 32'h2);
		rd(URX_OFF_DATA, 32'hc3);
		// Divisor 1 gives two clocks per sample, so 32 clocks per bit
		wr(URX_OFF_STATUS, 32'h0);
		wr(URX_OFF_BAUD, 32'h1);
		rd(URX_OFF_BAUD, 32'h1);
		i_line.send(8'h96, 8, 32, 0, 0, 1);
		rd(URX_OFF_STATUS, st(1, 0, 0, 0));
		rd(URX_OFF_DATA, 32'h96);
	endtask : t_noise_ds

	initial begin
		c_all = 32'h0;
		c_all[URX_CTRL_RXEN] = 1'b1;
		c_all[URX_CTRL_GIE] = 1'b1;
		c_noie = c_all;
		c_all[URX_CTRL_RXCIE] = 1'b1;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_basic();
		t_errors();
		t_overrun();
		t_flush();
		t_drain();
		t_noise_ds();
		close_out();
	end

	// Whole run needs well under this many cycles
	initial begin
		repeat (30000) @(posedge hclk);
		n_errors++;
		close_out();
	end
endmodule : tb_top
